// ==== logic/cii_btn_if.sv ====
`timescale 1ns/1ps
interface cii_btn_if #(parameter int W = 5);
   logic [W-1:0] rise;
   modport src (output rise);
   modport dst (input rise);
endinterface

// ==== logic/cii_pin_sync.sv ====
`timescale 1ns/1ps
module cii_pin_sync #(
   parameter int W = 5
) (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, active low
   input wire logic [W-1:0] pin, // raw console levels
   cii_btn_if.src evt // one-cycle rising-edge pulses
);
   logic [W-1:0] meta;
   logic [W-1:0] stable;
   logic [W-1:0] last;
   logic [W-1:0] rise_q;
   wire [W-1:0] next_rise = stable & ~last;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         stable <= '0;
         last <= '0;
         rise_q <= '0;
      end else begin
         meta <= pin;
         stable <= meta;
         last <= stable;
         rise_q <= next_rise;
      end
   end
   assign evt.rise = rise_q;
endmodule

// ==== logic/cii_pkg.sv ====
// Operation
// - sample contingency indicators only at ending pulse
// - contingency interrupt when error and contingency modes clear
// - contingency: set mode, save 0018, jump 0019
// - contingency mode blocks contingency and lower interrupts
// - processor error still interrupts during contingency mode
// - test/reset contingency select indicators one-hot bits
// - overflow on carry, bad divisor, zero divisor
// - overflow on load-time after unreset clock power loss
// - invalid opcode: immediate ending pulse, indicator bit 2
// - typewriter key release or print sets bit 3
// - keyboard request button sets bit 4
// - keyboard release button sets bit 5
// - stop button sets bit 6
// - io interrupt when error, contingency, io modes and inhibit clear
// - io interrupt: set mode, save 0020, jump 0021
// - higher class interrupts during io mode
// - io indicators keep setting during io mode
// - saved word: counter low, upper bits zero
// - class reset clears mode; all clear blocks one instruction
// - processor error: set mode, save 0016, jump 0017
package cii_pkg;
   localparam int CC_W = 15;
   localparam int SAVE_W = 25;
   localparam int SEL_W = 10;
   localparam int CONT_W = 6;
   localparam int BTN_W = 5;
   // memory words are decimal addresses
   localparam logic [CC_W-1:0] PE_SAVE = 15'h0010;
   localparam logic [CC_W-1:0] PE_JUMP = 15'h0011;
   localparam logic [CC_W-1:0] CONT_SAVE = 15'h0012;
   localparam logic [CC_W-1:0] CONT_JUMP = 15'h0013;
   localparam logic [CC_W-1:0] IO_SAVE = 15'h0014;
   localparam logic [CC_W-1:0] IO_JUMP = 15'h0015;
   // indicator index = select bit position minus one
   localparam int CI_OVF = 0;
   localparam int CI_INVOP = 1;
   localparam int CI_TYPE = 2;
   localparam int CI_KREQ = 3;
   localparam int CI_KREL = 4;
   localparam int CI_STOP = 5;
   localparam int BTN_KEY = 0;
   localparam int BTN_PRINT = 1;
   localparam int BTN_KREQ = 2;
   localparam int BTN_KREL = 3;
   localparam int BTN_STOP = 4;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] REG_PE = 8'h08;
   localparam logic [ADDR_W-1:0] REG_IO = 8'h0C;
   localparam int CTRL_INH = 0;
   localparam int STAT_PEM = 8;
   localparam int STAT_CM = 9;
   localparam int STAT_IOM = 10;
   localparam int STAT_BLK = 11;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {
      CII_NONE = 2'b00,
      CII_PE = 2'b01,
      CII_CONT = 2'b10,
      CII_IO = 2'b11
   } cii_class_t;
   typedef enum logic [2:0] {
      CII_OP_NONE = 3'b000,
      CII_OP_TEST_CONT = 3'b001,
      CII_OP_RESET_CONT = 3'b010,
      CII_OP_TEST_PE = 3'b011,
      CII_OP_RESET_PE = 3'b100,
      CII_OP_TEST_IO = 3'b101,
      CII_OP_RESET_IO = 3'b110
   } cii_op_t;
endpackage

// ==== logic/cii_top.sv ====
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module cii_top #(
   parameter int PE_W = 10,
   parameter int NCH = 8,
   parameter int DIV_W = 24
) (
   input wire logic aclk, // processor clock
   input wire logic aresetn, // sync reset, active low
   input wire logic [cii_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [cii_pkg::ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic end_pulse, // instruction ending pulse
   input wire logic [cii_pkg::CC_W-1:0] ctrl_counter, // control counter
   input wire cii_pkg::cii_op_t op, // test/reset instruction, one cycle
   input wire logic [cii_pkg::SEL_W-1:0] op_sel, // select bits 1..10
   input wire logic add_carry, // carry past top in add/subtract
   input wire logic div_check, // division operands valid
   input wire logic [DIV_W-1:0] divisor_mag, // divisor magnitude
   input wire logic [DIV_W-1:0] dividend_hi_mag, // upper half dividend
   input wire logic clk_power_drop, // program clock lost power
   input wire logic load_time_exec, // load-time instruction executes
   input wire logic prog_clock_reset, // program clock was reset
   input wire logic opcode_unimpl, // unimplemented opcode decoded
   input wire logic [PE_W-1:0] pe_set, // processor error events
   input wire logic [NCH-1:0] io_set, // channel io events
   input wire logic key_release_pin, // typewriter key released
   input wire logic print_pin, // typewriter printed
   input wire logic kb_req_pin, // keyboard request button
   input wire logic kb_rel_pin, // keyboard release button
   input wire logic stop_pin, // stop button
   output logic int_take, // forced transfer pulse
   output cii_pkg::cii_class_t int_class, // class taken
   output logic [cii_pkg::CC_W-1:0] save_addr, // word receiving counter
   output logic [cii_pkg::SAVE_W-1:0] save_word, // value to store
   output logic [cii_pkg::CC_W-1:0] jump_addr, // transfer target
   output logic test_valid, // test result pulse
   output logic test_hit, // selected indicator set
   output logic early_end // request immediate ending pulse
);
   import cii_pkg::*;

   cii_btn_if #(.W(BTN_W)) btn ();

   cii_pin_sync #(.W(BTN_W)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin({stop_pin, kb_rel_pin, kb_req_pin, print_pin, key_release_pin}),
      .evt(btn)
   );

   logic [CONT_W-1:0] cont_ind;
   logic [PE_W-1:0] pe_ind;
   logic [NCH-1:0] io_ind;
   logic pe_mode;
   logic cont_mode;
   logic io_mode;
   logic block;
   logic io_inhibit;
   logic pwr_lost;

   // indicator events
   wire div_ovf = div_check &&
      (divisor_mag < dividend_hi_mag || divisor_mag == '0);
   wire late_ovf = load_time_exec & pwr_lost;
   wire [CONT_W-1:0] cont_evt;
   assign cont_evt[CI_OVF] = add_carry | div_ovf | late_ovf;
   assign cont_evt[CI_INVOP] = opcode_unimpl;
   assign cont_evt[CI_TYPE] =
      btn.rise[BTN_KEY] | btn.rise[BTN_PRINT];
   assign cont_evt[CI_KREQ] = btn.rise[BTN_KREQ];
   assign cont_evt[CI_KREL] = btn.rise[BTN_KREL];
   assign cont_evt[CI_STOP] = btn.rise[BTN_STOP];

   // selective clears, set wins over clear
   wire rst_cont = (op == CII_OP_RESET_CONT);
   wire rst_pe = (op == CII_OP_RESET_PE);
   wire rst_io = (op == CII_OP_RESET_IO);
   wire [CONT_W-1:0] clr_cont =
      rst_cont ? op_sel[CONT_W-1:0] : '0;
   wire [PE_W-1:0] clr_pe = rst_pe ? op_sel[PE_W-1:0] : '0;
   wire [NCH-1:0] clr_io = rst_io ? op_sel[NCH-1:0] : '0;
   wire [CONT_W-1:0] next_cont = (cont_ind & ~clr_cont) | cont_evt;
   wire [PE_W-1:0] next_pe = (pe_ind & ~clr_pe) | pe_set;
   wire [NCH-1:0] next_io = (io_ind & ~clr_io) | io_set;

   // test instructions
   wire test_cont = (op == CII_OP_TEST_CONT);
   wire test_pe = (op == CII_OP_TEST_PE);
   wire test_io = (op == CII_OP_TEST_IO);
   wire next_hit =
      (test_cont && |(cont_ind & op_sel[CONT_W-1:0])) ||
      (test_pe && |(pe_ind & op_sel[PE_W-1:0])) ||
      (test_io && |(io_ind & op_sel[NCH-1:0]));

   // arbitration at the ending pulse only
   wire pe_go = end_pulse & |pe_ind & ~pe_mode & ~block;
   wire cont_go = end_pulse & |cont_ind & ~pe_mode & ~cont_mode
      & ~block;
   wire io_go = end_pulse & |io_ind & ~pe_mode & ~cont_mode & ~io_mode
      & ~io_inhibit & ~block;
   wire cii_class_t pick = pe_go ? CII_PE :
      cont_go ? CII_CONT :
      io_go ? CII_IO : CII_NONE;
   wire take_pe = (pick == CII_PE);
   wire take_cont = (pick == CII_CONT);
   wire take_io = (pick == CII_IO);
   wire [CC_W-1:0] next_save = take_pe ? PE_SAVE :
      take_cont ? CONT_SAVE : IO_SAVE;
   wire [CC_W-1:0] next_jump = take_pe ? PE_JUMP :
      take_cont ? CONT_JUMP : IO_JUMP;
   wire [SAVE_W-1:0] next_word =
      {{(SAVE_W-CC_W){1'b0}}, ctrl_counter};

   // mode flags: taking an interrupt sets, the class reset clears
   wire next_pe_mode = take_pe | (pe_mode & ~rst_pe);
   wire next_cont_mode =
      take_cont | (cont_mode & ~rst_cont);
   wire next_io_mode = take_io | (io_mode & ~rst_io);
   wire any_reset = rst_cont | rst_pe | rst_io;
   wire all_clear =
      (next_cont == '0) && (next_pe == '0) && (next_io == '0);
   // the blocked ending pulse is the reset instruction's own
   wire next_block = (any_reset & all_clear) |
      (block & ~end_pulse);
   wire next_pwr_lost = clk_power_drop |
      (pwr_lost & ~prog_clock_reset);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cont_ind <= '0;
         pe_ind <= '0;
         io_ind <= '0;
         pe_mode <= 1'b0;
         cont_mode <= 1'b0;
         io_mode <= 1'b0;
         block <= 1'b0;
         pwr_lost <= 1'b0;
      end else begin
         cont_ind <= next_cont;
         pe_ind <= next_pe;
         io_ind <= next_io;
         pe_mode <= next_pe_mode;
         cont_mode <= next_cont_mode;
         io_mode <= next_io_mode;
         block <= next_block;
         pwr_lost <= next_pwr_lost;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_take <= 1'b0;
         int_class <= CII_NONE;
         save_addr <= '0;
         save_word <= '0;
         jump_addr <= '0;
         test_valid <= 1'b0;
         test_hit <= 1'b0;
         early_end <= 1'b0;
      end else begin
         int_take <= (pick != CII_NONE);
         int_class <= pick;
         if (pick != CII_NONE) begin
            save_addr <= next_save;
            save_word <= next_word;
            jump_addr <= next_jump;
         end
         test_valid <= test_cont | test_pe | test_io;
         test_hit <= next_hit;
         early_end <= opcode_unimpl;
      end
   end

   // AXI4-Lite slave
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_have;
   logic w_have;
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire aw_now = aw_have | aw_hs;
   wire w_now = w_have | w_hs;
   wire [ADDR_W-1:0] wa = aw_hs ? s_axi_awaddr : aw_addr;
   wire [31:0] wd = w_hs ? s_axi_wdata : w_data;
   wire [3:0] ws = w_hs ? s_axi_wstrb : w_strb;
   wire do_write = aw_now & w_now & ~s_axi_bvalid;
   wire wr_ctrl = do_write && (wa == REG_CTRL);
   wire wr_ok = (wa == REG_CTRL) || (wa == REG_STAT) ||
      (wa == REG_PE) || (wa == REG_IO);
   wire b_done = s_axi_bvalid & s_axi_bready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         io_inhibit <= 1'b0;
      end else begin
         if (aw_hs) begin
            aw_addr <= s_axi_awaddr;
            aw_have <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_hs) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_have <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_DECERR;
         end
         if (wr_ctrl && ws[0]) begin
            io_inhibit <= wd[CTRL_INH];
         end
         if (b_done) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire [31:0] stat_word;
   assign stat_word[CONT_W-1:0] = cont_ind;
   assign stat_word[STAT_PEM-1:CONT_W] = '0;
   assign stat_word[STAT_PEM] = pe_mode;
   assign stat_word[STAT_CM] = cont_mode;
   assign stat_word[STAT_IOM] = io_mode;
   assign stat_word[STAT_BLK] = block;
   assign stat_word[31:STAT_BLK+1] = '0;
   wire [31:0] ctrl_word = {31'h0, io_inhibit};
   wire [31:0] pe_word = {{(32-PE_W){1'b0}}, pe_ind};
   wire [31:0] io_word = {{(32-NCH){1'b0}}, io_ind};
   wire rd_ctrl = (s_axi_araddr == REG_CTRL);
   wire rd_stat = (s_axi_araddr == REG_STAT);
   wire rd_pe = (s_axi_araddr == REG_PE);
   wire rd_io = (s_axi_araddr == REG_IO);
   wire rd_ok = rd_ctrl | rd_stat | rd_pe | rd_io;
   wire [31:0] rd_mux = rd_ctrl ? ctrl_word :
      rd_stat ? stat_word :
      rd_pe ? pe_word :
      rd_io ? io_word : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// ==== tb/cii_seq_model.sv ====
`timescale 1ns/1ps
module cii_seq_model (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, active low
   input wire logic step, // instruction finishing, one cycle
   input wire logic [14:0] cc_in, // counter for that instruction
   input wire logic early_end, // design asks for an ending pulse
   output logic end_pulse, // ending pulse
   output logic [14:0] ctrl_counter // control counter
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         end_pulse <= 1'b0;
         ctrl_counter <= 15'h0000;
      end else begin
         end_pulse <= step | early_end;
         // counter only meaningful with the pulse; scrambled otherwise
         ctrl_counter <= step ? cc_in : ~ctrl_counter;
      end
   end
endmodule

// ==== tb/cii_top_bench.sv ====
`timescale 1ns/1ps
module cii_top_bench;
   import cii_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, step;
   logic awready, wready, bvalid, arready, rvalid, end_pulse, int_take;
   logic test_valid, test_hit, early_end;
   logic [7:0] awaddr, araddr, io_set;
   logic [31:0] wdata, rdata, d, h;
   logic [1:0] bresp, rresp;
   logic [14:0] cc, ctrl_counter, save_addr, jump_addr, got_cc;
   logic [24:0] save_word;
   logic [9:0] op_sel, pe_set;
   logic [5:0] ev;
   logic [4:0] pins;
   logic [23:0] dv;
   cii_op_t op;
   cii_class_t int_class, got_cls;
   int n_fail, check_count, cyc;
   int t_e1[12] = '{1, 2, 2, 2, 16, 32, 4, 0, 0, 0, 0, 0};
   int t_e2[12] = '{0, 0, 0, 0, 8, 8, 0, 0, 0, 0, 0, 0};
   int t_dv[12] = '{7, 1, 0, 5, 7, 7, 7, 7, 7, 7, 7, 7};
   int t_pin[12] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 4, 8, 16};
   int t_bit[12] = '{0, 0, 0, 0, 0, 0, 1, 2, 2, 3, 4, 5};
   int t_hit[12] = '{1, 1, 1, 0, 1, 0, 1, 1, 1, 1, 1, 1};
   cii_top i_cii_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .end_pulse(end_pulse),
      .ctrl_counter(ctrl_counter), .op(op), .op_sel(op_sel),
      .add_carry(ev[0]), .div_check(ev[1]), .divisor_mag(dv),
      .dividend_hi_mag(24'h000005), .clk_power_drop(ev[4]),
      .load_time_exec(ev[3]), .prog_clock_reset(ev[5]),
      .opcode_unimpl(ev[2]), .pe_set(pe_set), .io_set(io_set),
      .key_release_pin(pins[0]), .print_pin(pins[1]),
      .kb_req_pin(pins[2]), .kb_rel_pin(pins[3]), .stop_pin(pins[4]),
      .int_take(int_take), .int_class(int_class), .save_addr(save_addr),
      .save_word(save_word), .jump_addr(jump_addr),
      .test_valid(test_valid), .test_hit(test_hit), .early_end(early_end));
   cii_seq_model i_cii_seq_model (.aclk(aclk), .aresetn(aresetn),
      .step(step), .cc_in(cc), .early_end(early_end),
      .end_pulse(end_pulse), .ctrl_counter(ctrl_counter));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc > 5000) begin
         n_fail++;
         report_and_stop;
      end
      if (int_take === 1'b1) begin
         got_cls = int_class;
         got_cc = save_word[14:0];
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] r = RESP_OKAY);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r = RESP_OKAY);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, r});
   endtask
   task automatic opdo(input cii_op_t o, input logic [9:0] s);
      @(posedge aclk);
      op <= o;
      op_sel <= s;
      @(posedge aclk);
      op <= CII_OP_NONE;
      @(negedge aclk);
      h = {31'h0, test_hit};
   endtask
   task automatic pulse(input logic [5:0] e, input logic [9:0] p,
      input logic [7:0] i);
      @(posedge aclk);
      ev <= e;
      pe_set <= p;
      io_set <= i;
      @(posedge aclk);
      ev <= 6'h00;
      pe_set <= 10'h000;
      io_set <= 8'h00;
   endtask
   task automatic fire(input logic [14:0] c, input cii_class_t k);
      got_cls = CII_NONE;
      got_cc = 15'h0000;
      @(posedge aclk);
      cc <= c;
      step <= 1'b1;
      @(posedge aclk);
      step <= 1'b0;
      repeat (5) @(posedge aclk);
      chk({30'h0, got_cls}, {30'h0, k});
      if (k != CII_NONE) chk({17'h0, got_cc}, {17'h0, c});
   endtask
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, step} = 6'h00;
      {awaddr, araddr, io_set, wdata, cc, op_sel, pe_set} = '0;
      {ev, pins, dv} = '0;
      op = CII_OP_NONE;
      n_fail = 0;
      check_count = 0;
      cyc = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      wr(8'h10, 32'h1, RESP_DECERR);
      rd(REG_CTRL, 32'h0);
      rd(REG_STAT, 32'h0);
      rd(8'h10, 32'h0, RESP_DECERR);
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         dv <= t_dv[i][23:0];
         opdo(CII_OP_RESET_CONT, 10'h03F);
         pulse(t_e1[i][5:0], 10'h000, 8'h00);
         pulse(t_e2[i][5:0], 10'h000, 8'h00);
         pins <= t_pin[i][4:0];
         repeat (6) @(posedge aclk);
         pins <= 5'h00;
         repeat (6) @(posedge aclk);
         opdo(CII_OP_TEST_CONT, 10'(1 << t_bit[i]));
         chk(h, 32'(t_hit[i]));
         d = 32'(t_hit[i] << t_bit[i]) | 32'(i != 6) << STAT_BLK;
         rd(REG_STAT, d);
      end
      $display("test causes done");
      fire(15'h0AAA, CII_NONE);
      pulse(6'h00, 10'h000, 8'h01);
      fire(15'h1234, CII_CONT);
      pulse(6'h00, 10'h000, 8'h02);
      fire(15'h0555, CII_NONE);
      rd(REG_STAT, 32'h20 | 32'h1 << STAT_CM);
      pulse(6'h00, 10'h001, 8'h00);
      fire(15'h0321, CII_PE);
      opdo(CII_OP_TEST_PE, 10'h001);
      chk(h, 32'h1);
      $display("test contingency done");
      opdo(CII_OP_RESET_PE, 10'h001);
      opdo(CII_OP_RESET_CONT, 10'h020);
      wr(REG_CTRL, 32'h1);
      fire(15'h0111, CII_NONE);
      wr(REG_CTRL, 32'h0);
      fire(15'h0777, CII_IO);
      pulse(6'h00, 10'h000, 8'h80);
      rd(REG_IO, 32'h83);
      pulse(6'h01, 10'h000, 8'h00);
      fire(15'h7FFF, CII_CONT);
      opdo(CII_OP_TEST_IO, 10'h080);
      chk(h, 32'h1);
      opdo(CII_OP_RESET_IO, 10'h001);
      rd(REG_IO, 32'h82);
      $display("test io done");
      report_and_stop;
   end
endmodule

// ==== tb/cii_top_monitor.sv ====
`timescale 1ns/1ps
module cii_top_monitor (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, active low
   input wire logic end_pulse, // ending pulse
   input wire logic [cii_pkg::CC_W-1:0] ctrl_counter, // counter
   input wire cii_pkg::cii_op_t op, // test/reset instruction
   input wire logic opcode_unimpl, // unimplemented opcode
   input wire logic int_take, // interrupt taken
   input wire cii_pkg::cii_class_t int_class, // class taken
   input wire logic [cii_pkg::CC_W-1:0] save_addr, // save word address
   input wire logic [cii_pkg::SAVE_W-1:0] save_word, // saved value
   input wire logic [cii_pkg::CC_W-1:0] jump_addr, // jump target
   input wire logic test_valid, // test result pulse
   input wire logic early_end // immediate ending request
);
   import cii_pkg::*;
   logic cm_seen;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // tracks contingency mode from its take until its reset instruction
   always_ff @(posedge aclk) begin
      if (!aresetn || op == CII_OP_RESET_CONT) begin
         cm_seen <= 1'b0;
      end else if (int_take && int_class == CII_CONT) begin
         cm_seen <= 1'b1;
      end
   end
   AST_TAKE_CAUSE: assert property (int_take |-> $past(end_pulse))
      else $error("take without ending pulse");
   AST_CONT_VEC: assert property (
      int_take && int_class == CII_CONT |->
      save_addr == CONT_SAVE && jump_addr == CONT_JUMP)
      else $error("contingency vector wrong");
   AST_IO_VEC: assert property (
      int_take && int_class == CII_IO |->
      save_addr == IO_SAVE && jump_addr == IO_JUMP)
      else $error("io vector wrong");
   AST_PE_VEC: assert property (
      int_take && int_class == CII_PE |->
      save_addr == PE_SAVE && jump_addr == PE_JUMP)
      else $error("processor error vector wrong");
   AST_SAVE_WORD: assert property (
      int_take |-> save_word == {10'h000, $past(ctrl_counter)})
      else $error("saved word wrong");
   AST_EARLY_END: assert property (opcode_unimpl |=> early_end)
      else $error("no early ending pulse");
   AST_TEST_VALID: assert property (
      op inside {CII_OP_TEST_CONT, CII_OP_TEST_PE, CII_OP_TEST_IO}
      ##1 1'b1 |-> test_valid)
      else $error("test result missing");
   AST_CONT_MASK: assert property (
      cm_seen && int_take |-> int_class == CII_PE)
      else $error("take during contingency mode");
   cover property (int_take && int_class == CII_PE);
   cover property (int_take && int_class == CII_CONT);
   cover property (int_take && int_class == CII_IO);
endmodule

bind cii_top cii_top_monitor i_cii_top_monitor (.aclk(aclk),
   .aresetn(aresetn), .end_pulse(end_pulse), .ctrl_counter(ctrl_counter),
   .op(op), .opcode_unimpl(opcode_unimpl), .int_take(int_take),
   .int_class(int_class), .save_addr(save_addr), .save_word(save_word),
   .jump_addr(jump_addr), .test_valid(test_valid), .early_end(early_end));
